// file: hw/pwc_pkg.sv
// Functional notes
// - Data byte committed during its acknowledge slot
// - Stop or restart before acknowledge discards byte
// - Back-to-back commands to 00h, 01h, 04h accepted
// - Stream may change address; master ends it
// - High-voltage pin level qualifies the command
// - Read: control, command, restart, control, two bytes
// - Read pointer follows last valid command, else 00h
// - Address pointer kept across read transactions
// - Master acks to continue, nacks to end reads
// - During nonvolatile write, only the status read is refused
// - Undefined command: release data, wait for start
// - Increment valid only at 00h and 01h
// - Increment saturates at full scale
// - Wiper updates right at command acknowledge
// - Increment may be followed by any command
// - Decrement valid only at 00h and 01h
// - Decrement stops at zero
// - Command byte: location, operation, data msb
// - Invalid combination not acknowledged, then ignored
// - Write value is data msb joined with byte
package pwc_pkg;
  // Memory locations
  localparam logic [3:0] LOC_WIPER0 = 4'h0;
  localparam logic [3:0] LOC_WIPER1 = 4'h1;
  localparam logic [3:0] LOC_TCON = 4'h4;
  localparam logic [3:0] LOC_STATUS = 4'h5;
  // Operation codes
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_INC = 2'h1;
  localparam logic [1:0] OP_DEC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // Command byte field positions
  localparam int CMD_LOC_LSB = 4;
  localparam int CMD_OP_LSB = 2;
  localparam int CMD_D8_POS = 0;
  // Reset values
  localparam logic [8:0] WIPER_RESET = 9'h000;
  localparam logic [8:0] TCON_RESET = 9'h000;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  localparam int WIPER_BITS_DEFAULT = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_DONE = 4'h9;
  // Host timing: SCL period derived from system clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 640;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Host register map and fields
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h1;
  localparam logic [3:0] HREG_RDATA = 4'h2;
  localparam int HCMD_DATA_LSB = 8;
  localparam int HCMD_HV_POS = 16;
  localparam int HSTAT_BUSY_POS = 0;
  localparam int HSTAT_NACK_POS = 1;

  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_CTRL = 5'b00010,
    D_CMD = 5'b00100,
    D_WDATA = 5'b01000,
    D_RDATA = 5'b10000
  } pwc_dstate_e;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_START = 4'b0010,
    H_BIT = 4'b0100,
    H_STOP = 4'b1000
  } pwc_hstate_e;
endpackage : pwc_pkg

// file: hw/pwc_if.sv
`timescale 1ns/10ps
interface pwc_if;
  logic hostSclOe;
  logic hostSdaOe;
  logic devSdaOe;
  logic addrBitZero;
  logic highVoltage;
  logic scl;
  logic sda;
  // Open-drain wired-AND with pull-ups
  assign scl = ~hostSclOe;
  assign sda = ~(hostSdaOe | devSdaOe);
  modport device(input scl, input sda, input addrBitZero, input highVoltage, output devSdaOe);
  modport host(input sda, output hostSclOe, output hostSdaOe, output addrBitZero,
               output highVoltage);
endinterface : pwc_if

// file: hw/pwc_device.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module pwc_device #(
  parameter int WIPER_BITS = pwc_pkg::WIPER_BITS_DEFAULT,
  parameter logic [6:0] DEV_ADDR = pwc_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,          // System clock
  input wire logic nrst,         // Async reset, active low
  pwc_if.device bus,             // Serial link
  input wire logic nvBusy,       // Nonvolatile write cycle running
  input wire logic [8:0] statusWord, // Value returned at status location
  output logic [8:0] wiper0,     // Volatile wiper 0
  output logic [8:0] wiper1,     // Volatile wiper 1
  output logic [8:0] tcon,       // Terminal control
  output logic hvActive          // Last valid command was high voltage
);
  // Full scale: 80h for 7-bit, 100h for 8-bit
  localparam logic [8:0] FULL = 9'(1 << WIPER_BITS);

  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] a0Sync;
  logic [1:0] hvSync;
  logic sclD;
  logic sdaD;
  logic sdaOe;
  pwc_pkg::pwc_dstate_e state;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic [7:0] txByte;
  logic lowNext;
  logic [3:0] cmdLoc;
  logic [1:0] cmdOp;
  logic cmdD8;
  logic [3:0] ptr;
  logic [8:0] readVal;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic ackRise;

  function automatic logic cmdValid(input logic [3:0] loc, input logic [1:0] op,
                                    input logic busy);
    logic ok;
    ok = 1'b0;
    unique case (loc)
      pwc_pkg::LOC_WIPER0, pwc_pkg::LOC_WIPER1: ok = 1'b1;
      pwc_pkg::LOC_TCON: ok = (op == pwc_pkg::OP_WRITE) || (op == pwc_pkg::OP_READ);
      pwc_pkg::LOC_STATUS: ok = (op == pwc_pkg::OP_READ) && !busy;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : cmdValid

  function automatic logic [8:0] stepWiper(input logic [8:0] v, input logic up);
    logic [8:0] r;
    r = v;
    if (up && (v < FULL)) begin
      r = v + 9'h001;
    end else if (!up && (v != 9'h000) && (v <= FULL)) begin
      r = v - 9'h001;
    end
    return r;
  endfunction : stepWiper

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      a0Sync <= 2'h0;
      hvSync <= 2'h0;
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], bus.scl};
      sdaSync <= {sdaSync[0], bus.sda};
      a0Sync <= {a0Sync[0], bus.addrBitZero};
      hvSync <= {hvSync[0], bus.highVoltage};
      sclD <= sclSync[1];
      sdaD <= sdaSync[1];
    end
  end

  // Bus events from the synchronised levels
  assign sclRise = sclSync[1] & ~sclD;
  assign sclFall = ~sclSync[1] & sclD;
  assign startSeen = sclSync[1] & sclD & sdaD & ~sdaSync[1];
  assign stopSeen = sclSync[1] & sclD & ~sdaD & sdaSync[1];
  assign ackRise = sclRise && (bitCnt == pwc_pkg::ACK_SLOT);
  assign bus.devSdaOe = sdaOe;

  // Read mux; unmapped locations read zero
  always_comb begin
    unique case (ptr)
      pwc_pkg::LOC_WIPER0: readVal = wiper0;
      pwc_pkg::LOC_WIPER1: readVal = wiper1;
      pwc_pkg::LOC_TCON: readVal = tcon;
      pwc_pkg::LOC_STATUS: readVal = statusWord;
      default: readVal = 9'h000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit engine and command state machine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= pwc_pkg::D_IDLE;
      bitCnt <= 4'h0;
      shift <= 8'h00;
      txByte <= 8'h00;
      lowNext <= 1'b0;
      sdaOe <= 1'b0;
      cmdLoc <= 4'h0;
      cmdOp <= 2'h0;
      cmdD8 <= 1'b0;
      ptr <= pwc_pkg::PTR_RESET;
      hvActive <= 1'b0;
    end else if (startSeen) begin
      // Any start resynchronises, also after an error
      state <= pwc_pkg::D_CTRL;
      bitCnt <= 4'h0;
      sdaOe <= 1'b0;
    end else if (stopSeen) begin
      state <= pwc_pkg::D_IDLE;
      bitCnt <= 4'h0;
      sdaOe <= 1'b0;
    end else if (state != pwc_pkg::D_IDLE) begin
      if (sclRise) begin
        if (bitCnt < pwc_pkg::ACK_SLOT) begin
          shift <= {shift[6:0], sdaSync[1]};
        end
        bitCnt <= bitCnt + 4'h1;
        if (ackRise) begin
          unique case (state)
            pwc_pkg::D_CTRL: begin
              state <= shift[0] ? pwc_pkg::D_RDATA : pwc_pkg::D_CMD;
              txByte <= {7'h00, readVal[8]};
              lowNext <= 1'b1;
            end
            pwc_pkg::D_CMD: begin
              // Stay ready for another command with no restart
              state <= (cmdOp == pwc_pkg::OP_WRITE) ? pwc_pkg::D_WDATA : pwc_pkg::D_CMD;
            end
            pwc_pkg::D_WDATA: state <= pwc_pkg::D_CMD;
            pwc_pkg::D_RDATA: begin
              if (sdaSync[1]) begin
                state <= pwc_pkg::D_IDLE;
              end
              txByte <= lowNext ? readVal[7:0] : {7'h00, readVal[8]};
              lowNext <= ~lowNext;
            end
            default: state <= pwc_pkg::D_IDLE;
          endcase
        end
      end else if (sclFall) begin
        if (bitCnt == pwc_pkg::ACK_SLOT) begin
          unique case (state)
            pwc_pkg::D_CTRL: begin
              if (shift[7:1] == {DEV_ADDR[6:1], a0Sync[1]}) begin
                sdaOe <= 1'b1;
              end else begin
                state <= pwc_pkg::D_IDLE;
              end
            end
            pwc_pkg::D_CMD: begin
              // Decode location, operation and data msb
              if (cmdValid(shift[7:4], shift[3:2], nvBusy)) begin
                sdaOe <= 1'b1;
                cmdLoc <= shift[7:pwc_pkg::CMD_LOC_LSB];
                cmdOp <= shift[pwc_pkg::CMD_OP_LSB+:2];
                cmdD8 <= shift[pwc_pkg::CMD_D8_POS];
                ptr <= shift[7:pwc_pkg::CMD_LOC_LSB];
                hvActive <= hvSync[1];
              end else begin
                state <= pwc_pkg::D_IDLE;
              end
            end
            pwc_pkg::D_WDATA: sdaOe <= 1'b1;
            pwc_pkg::D_RDATA: sdaOe <= 1'b0; // Master drives its ack
            default: sdaOe <= 1'b0;
          endcase
        end else if (bitCnt == pwc_pkg::BYTE_DONE) begin
          bitCnt <= 4'h0;
          sdaOe <= (state == pwc_pkg::D_RDATA) & ~txByte[7];
        end else if (state == pwc_pkg::D_RDATA) begin
          sdaOe <= ~txByte[3'(4'h7 - bitCnt)];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Volatile registers; a stop before the ack slot never reaches here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wiper0 <= pwc_pkg::WIPER_RESET;
      wiper1 <= pwc_pkg::WIPER_RESET;
      tcon <= pwc_pkg::TCON_RESET;
    end else if (ackRise && (state == pwc_pkg::D_WDATA)) begin
      unique case (cmdLoc)
        pwc_pkg::LOC_WIPER0: wiper0 <= {cmdD8, shift};
        pwc_pkg::LOC_WIPER1: wiper1 <= {cmdD8, shift};
        pwc_pkg::LOC_TCON: tcon <= {cmdD8, shift};
        default: tcon <= tcon;
      endcase
    end else if (ackRise && (state == pwc_pkg::D_CMD) &&
                 ((cmdOp == pwc_pkg::OP_INC) || (cmdOp == pwc_pkg::OP_DEC))) begin
      // Takes effect at the command ack itself
      if (cmdLoc == pwc_pkg::LOC_WIPER0) begin
        wiper0 <= stepWiper(wiper0, cmdOp == pwc_pkg::OP_INC);
      end else begin
        wiper1 <= stepWiper(wiper1, cmdOp == pwc_pkg::OP_INC);
      end
    end
  end
endmodule : pwc_device

// file: hw/pwc_host.sv
`timescale 1ns/10ps
module pwc_host #(
  parameter logic [6:0] DEV_ADDR = pwc_pkg::DEV_ADDR_DEFAULT,
  parameter int QTR = pwc_pkg::QTR_CYCLES,
  parameter logic A0_LEVEL = 1'b0
) (
  input wire logic clk,             // System clock
  input wire logic nrst,            // Async reset, active low
  pwc_if.host bus,                  // Serial link
  input wire logic [3:0] regAddr,   // Register address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr,           // Write strobe
  input wire logic regRd,           // Read strobe
  output logic [31:0] regRdata      // Read data, one cycle later
);
  logic [1:0] sdaSync;
  logic [7:0] cmdByte;
  logic [7:0] dataByte;
  logic go;
  logic busy;
  logic nack;
  logic [15:0] rdWord;
  pwc_pkg::pwc_hstate_e state;
  logic [7:0] qCnt;
  logic [1:0] q;
  logic [3:0] bitIdx;
  logic [2:0] byteNo;
  logic [7:0] txSh;
  logic [7:0] rxSh;
  logic ackBit;
  logic tick;
  logic isRead;
  logic isWrite;

  assign tick = (qCnt == 8'(QTR - 1));
  assign isRead = cmdByte[3:2] == pwc_pkg::OP_READ;
  assign isWrite = cmdByte[3:2] == pwc_pkg::OP_WRITE;

  // Byte sent at each step; all ones releases the line for reception
  function automatic logic [7:0] byteFor(input logic [2:0] n, input logic rd);
    logic [7:0] b;
    b = 8'hFF;
    unique case (n)
      3'h0: b = {DEV_ADDR[6:1], A0_LEVEL, 1'b0};
      3'h1: b = cmdByte;
      3'h2: b = rd ? {DEV_ADDR[6:1], A0_LEVEL, 1'b1} : dataByte;
      default: b = 8'hFF;
    endcase
    return b;
  endfunction : byteFor

  //////////////////////////////////////////////////////////////////////////////
  // Register port; a command written while busy is dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmdByte <= 8'h00;
      dataByte <= 8'h00;
      bus.highVoltage <= 1'b0;
      bus.addrBitZero <= 1'b0;
      go <= 1'b0;
      regRdata <= 32'h0000_0000;
    end else begin
      bus.addrBitZero <= A0_LEVEL;
      go <= 1'b0;
      if (regWr && (regAddr == pwc_pkg::HREG_CMD) && !busy && !go) begin
        cmdByte <= regWdata[7:0];
        dataByte <= regWdata[pwc_pkg::HCMD_DATA_LSB+:8];
        bus.highVoltage <= regWdata[pwc_pkg::HCMD_HV_POS];
        go <= 1'b1;
      end
      regRdata <= 32'h0000_0000;
      if (regRd) begin
        unique case (regAddr)
          pwc_pkg::HREG_STATUS: regRdata <= {30'h0000_0000, nack, busy | go};
          pwc_pkg::HREG_RDATA: regRdata <= {16'h0000, rdWord};
          default: regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Quarter-period divider; held at zero while idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      qCnt <= 8'h00;
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], bus.sda};
      qCnt <= (tick || (state == pwc_pkg::H_IDLE)) ? 8'h00 : qCnt + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: start, bytes with ack slots, stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= pwc_pkg::H_IDLE;
      q <= 2'h0;
      bitIdx <= 4'h0;
      byteNo <= 3'h0;
      txSh <= 8'hFF;
      rxSh <= 8'h00;
      ackBit <= 1'b1;
      busy <= 1'b0;
      nack <= 1'b0;
      rdWord <= 16'h0000;
      bus.hostSclOe <= 1'b0;
      bus.hostSdaOe <= 1'b0;
    end else if (state == pwc_pkg::H_IDLE) begin
      q <= 2'h0;
      if (go) begin
        state <= pwc_pkg::H_START;
        busy <= 1'b1;
        nack <= 1'b0;
        byteNo <= 3'h0;
      end
    end else if (tick) begin
      q <= q + 2'h1;
      unique case (state)
        pwc_pkg::H_START: begin
          // Doubles as repeated start when entered with SCL low
          unique case (q)
            2'h0: bus.hostSdaOe <= 1'b0;
            2'h1: bus.hostSclOe <= 1'b0;
            2'h2: bus.hostSdaOe <= 1'b1;
            default: begin
              bus.hostSclOe <= 1'b1;
              txSh <= byteFor(byteNo, isRead);
              bitIdx <= 4'h0;
              state <= pwc_pkg::H_BIT;
            end
          endcase
        end
        pwc_pkg::H_BIT: begin
          unique case (q)
            2'h0: begin
              if (bitIdx == pwc_pkg::ACK_SLOT) begin
                bus.hostSdaOe <= (byteNo == 3'h3);
              end else begin
                bus.hostSdaOe <= ~txSh[7];
              end
            end
            2'h1: bus.hostSclOe <= 1'b0;
            2'h2: begin
              if (bitIdx == pwc_pkg::ACK_SLOT) begin
                ackBit <= sdaSync[1];
              end else begin
                rxSh <= {rxSh[6:0], sdaSync[1]};
                txSh <= {txSh[6:0], 1'b1};
              end
            end
            default: begin
              bus.hostSclOe <= 1'b1;
              if (bitIdx != pwc_pkg::ACK_SLOT) begin
                bitIdx <= bitIdx + 4'h1;
              end else begin
                bitIdx <= 4'h0;
                txSh <= byteFor(byteNo + 3'h1, isRead);
                byteNo <= byteNo + 3'h1;
                if (byteNo < 3'h3 && ackBit) begin
                  nack <= 1'b1; // Device refused: end here
                  state <= pwc_pkg::H_STOP;
                end else begin
                  unique case (byteNo)
                    3'h1: state <= isRead ? pwc_pkg::H_START :
                          (isWrite ? pwc_pkg::H_BIT : pwc_pkg::H_STOP);
                    3'h2: state <= isRead ? pwc_pkg::H_BIT : pwc_pkg::H_STOP;
                    3'h3: begin
                      rdWord[15:8] <= rxSh;
                      state <= pwc_pkg::H_BIT;
                    end
                    3'h4: begin
                      rdWord[7:0] <= rxSh;
                      state <= pwc_pkg::H_STOP;
                    end
                    default: state <= pwc_pkg::H_BIT;
                  endcase
                end
              end
            end
          endcase
        end
        pwc_pkg::H_STOP: begin
          unique case (q)
            2'h0: bus.hostSdaOe <= 1'b1;
            2'h1: bus.hostSclOe <= 1'b0;
            2'h2: bus.hostSdaOe <= 1'b0;
            default: begin
              state <= pwc_pkg::H_IDLE;
              busy <= 1'b0;
            end
          endcase
        end
        default: state <= pwc_pkg::H_IDLE;
      endcase
    end
  end
endmodule : pwc_host

// file: tb/pwc_link_monitor.sv
`timescale 1ns/10ps
module pwc_link_monitor (
  input wire logic clk,         // System clock
  input wire logic nrst,        // Async reset, active low
  input wire logic hostSclOe,   // Host pulls clock line
  input wire logic hostSdaOe,   // Host pulls data line
  input wire logic devSdaOe,    // Device pulls data line
  input wire logic addrBitZero, // Address pin level
  input wire logic highVoltage, // Qualifier level
  input wire logic scl,         // Resolved clock line
  input wire logic sda          // Resolved data line
);
  logic sclQ;
  logic sdaQ;
  logic rw;
  logic [4:0] bitCnt;
  logic [7:0] shReg;
  logic [7:0] cmdByte;
  logic rise;
  logic start;
  logic stop;

  function automatic logic cmd_ok(input logic [7:0] c);
    logic [3:0] l;
    logic [1:0] o;
    l = c[7:4];
    o = c[3:2];
    return (l == pwc_pkg::LOC_WIPER0) || (l == pwc_pkg::LOC_WIPER1)
      || (l == pwc_pkg::LOC_TCON && (o == pwc_pkg::OP_WRITE || o == pwc_pkg::OP_READ))
      || (l == pwc_pkg::LOC_STATUS && o == pwc_pkg::OP_READ);
  endfunction : cmd_ok

  // Line events seen by the system clock
  assign rise = scl & ~sclQ;
  assign start = scl & sclQ & sdaQ & ~sda;
  assign stop = scl & sclQ & ~sdaQ & sda;

  // Line history, idle level is high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
    end
  end

  // Bit position in frame; a restart opens a new frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt <= 5'h00;
    end else if (start) begin
      bitCnt <= 5'h00;
    end else if (rise) begin
      bitCnt <= bitCnt + 5'h01;
    end
  end

  // Shifted bits, direction bit and command byte of the frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shReg <= 8'h00;
      rw <= 1'b0;
      cmdByte <= 8'h00;
    end else if (rise) begin
      shReg <= {shReg[6:0], sda};
      if (bitCnt == 5'd7) begin
        rw <= sda;
      end
      if (bitCnt == 5'd17) begin
        cmdByte <= shReg;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  ctrl_ack_a: assert property (rise && bitCnt == 5'd8 |-> !sda)
    else $error("control byte not acknowledged");
  cmd_ack_a: assert property (rise && bitCnt == 5'd17 && !rw
      && !(shReg[7:4] == pwc_pkg::LOC_STATUS && shReg[3:2] == pwc_pkg::OP_READ)
      |-> sda == !cmd_ok(shReg)) else $error("command acknowledge wrong");
  data_ack_a: assert property (rise && bitCnt == 5'd26 && !rw
      && cmdByte[3:2] == pwc_pkg::OP_WRITE && cmd_ok(cmdByte) |-> !sda)
    else $error("data byte not acknowledged");
  read_high_a: assert property (rise && rw && bitCnt >= 5'd9 && bitCnt <= 5'd15 |-> !sda)
    else $error("unused high bits not zero");
  nack_quiet_a: assert property (rise && bitCnt == 5'd17 && !rw && sda |=> !devSdaOe [*8])
    else $error("device drives after refusal");
  dev_edge_a: assert property ($changed(devSdaOe) |-> !scl)
    else $error("device moved data while clock high");
  stop_release_a: assert property (stop |-> !devSdaOe [*4])
    else $error("device holds line after stop");
  scl_high_a: assert property ($rose(scl) |-> scl [*6])
    else $error("clock high phase too short");
  start_low_a: assert property (start |-> ##[1:16] !scl)
    else $error("no clock after start");
  // Master must leave the line to the device while it sends the high byte
  host_quiet_a: assert property (rise && rw && bitCnt inside {[5'd9:5'd16]}
      |-> !hostSdaOe) else $error("host drives data line during read byte");
  pin_steady_a: assert property (rise |-> $stable(highVoltage) && $stable(addrBitZero))
    else $error("qualifier pins moved inside a frame");
  stop_idle_a: assert property (stop |-> !hostSclOe [*4])
    else $error("clock runs after stop");
endmodule : pwc_link_monitor

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [31:0] val; logic [31:0] mask;} pwc_note_s;
  localparam logic [8:0] FULL = 9'h100;
  logic clk = 1'b0;
  logic nrst, regWr, regRd, nvBusy, hvActive, chk, snap, hvm;
  logic rdPend = 1'b0;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [8:0] statusWord, wiper0, wiper1, tcon;
  logic [8:0] m[3];
  logic [3:0] locs[3] = '{4'h0, 4'h1, 4'h4};
  logic [5:0] bads[8] = '{6'h11, 6'h16, 6'h14, 6'h0B, 6'h18, 6'h3D, 6'h12, 6'h0C};
  int num_errors = 0;
  int n_checks = 0;
  int seed = 80;
  pwc_note_s regQ[$];
  logic [27:0] outQ[$];

  pwc_if link();
  pwc_device #(.WIPER_BITS(8)) pwc_device_inst (.clk(clk), .nrst(nrst), .bus(link.device),
    .nvBusy(nvBusy), .statusWord(statusWord), .wiper0(wiper0), .wiper1(wiper1), .tcon(tcon),
    .hvActive(hvActive));
  pwc_host pwc_host_inst (.clk(clk), .nrst(nrst), .bus(link.host), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  pwc_link_monitor pwc_link_monitor_inst (.clk(clk), .nrst(nrst),
    .hostSclOe(link.hostSclOe), .hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe),
    .addrBitZero(link.addrBitZero), .highVoltage(link.highVoltage), .scl(link.scl),
    .sda(link.sda));

  // 25 MHz system clock
  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task cmp_reg(input pwc_note_s n);
    n_checks++;
    if ((regRdata & n.mask) !== n.val) begin
      num_errors++;
      $display("mismatch at %0t: register %h expected %h", $time, regRdata & n.mask, n.val);
    end
  endtask : cmp_reg

  task cmp_out(input logic [27:0] e);
    n_checks++;
    if ({hvActive, tcon, wiper1, wiper0} !== e) begin
      num_errors++;
      $display("mismatch at %0t: outputs %h expected %h", $time,
        {hvActive, tcon, wiper1, wiper0}, e);
    end
  endtask : cmp_out

  // Watcher: each result is matched with the oldest note
  always @(posedge clk) begin
    if (rdPend) cmp_reg(regQ.pop_front());
    if (snap) cmp_out(outQ.pop_front());
    rdPend <= regRd & chk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic c);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    chk <= c;
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd

  task expect_reg(input logic [3:0] a, input logic [31:0] val, input logic [31:0] mk);
    regQ.push_back('{val, mk});
    rd(a, 1'b1);
  endtask : expect_reg

  // Poll busy; a stuck link is cut short by the bound
  task wait_idle;
    int i;
    logic b;
    b = 1'b1;
    for (i = 0; i < 4000 && b !== 1'b0; i++) begin
      rd(pwc_pkg::HREG_STATUS, 1'b0);
      @(negedge clk);
      b = regRdata[pwc_pkg::HSTAT_BUSY_POS];
    end
    if (b !== 1'b0) num_errors++;
  endtask : wait_idle

  task check_outs;
    @(posedge clk);
    outQ.push_back({hvm, m[2], m[1], m[0]});
    snap <= 1'b1;
    @(posedge clk);
    snap <= 1'b0;
  endtask : check_outs

  // One link transaction, then status and all outputs against the model
  task cmd(input logic [3:0] loc, input logic [1:0] op, input logic [8:0] d,
           input logic hv, input logic bad);
    int k;
    k = (loc == pwc_pkg::LOC_TCON) ? 2 : int'(loc[0]);
    wr(pwc_pkg::HREG_CMD, {15'h0000, hv, d[7:0], loc, op, 1'b0, d[8]});
    wait_idle();
    expect_reg(pwc_pkg::HREG_STATUS, {30'h0000_0000, bad, 1'b0}, 32'h0000_0003);
    if (!bad) begin
      hvm = hv;
      case (op)
        pwc_pkg::OP_WRITE: m[k] = d;
        pwc_pkg::OP_INC: if (m[k] < FULL) m[k] = m[k] + 9'h001;
        pwc_pkg::OP_DEC: if (m[k] != 9'h000 && m[k] <= FULL) m[k] = m[k] - 9'h001;
        default: ;
      endcase
    end
    check_outs();
  endtask : cmd

  task readback(input logic [3:0] loc, input logic [8:0] e);
    cmd(loc, pwc_pkg::OP_READ, 9'h000, 1'b0, 1'b0);
    expect_reg(pwc_pkg::HREG_RDATA, {23'h00_0000, e}, 32'h0000_FFFF);
  endtask : readback

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0000_0000;
    regWr = 1'b0;
    regRd = 1'b0;
    chk = 1'b0;
    snap = 1'b0;
    nvBusy = 1'b0;
    statusWord = 9'($random(seed));
    m = '{default: 9'h000};
    hvm = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (locs[i]) begin
      cmd(locs[i], pwc_pkg::OP_WRITE, 9'($random(seed)), 1'b0, 1'b0);
      readback(locs[i], m[i]);
    end
    cmd(4'h0, pwc_pkg::OP_WRITE, 9'($random(seed)), 1'b1, 1'b0);
    readback(4'h0, m[0]);
    $display("test writes and reads done");
    cmd(4'h0, pwc_pkg::OP_WRITE, 9'h0FF, 1'b0, 1'b0);
    repeat (2) cmd(4'h0, pwc_pkg::OP_INC, 9'h000, 1'b0, 1'b0);
    cmd(4'h0, pwc_pkg::OP_DEC, 9'h000, 1'b0, 1'b0);
    cmd(4'h1, pwc_pkg::OP_WRITE, 9'h000, 1'b0, 1'b0);
    repeat (2) cmd(4'h1, pwc_pkg::OP_DEC, 9'h000, 1'b0, 1'b0);
    cmd(4'h1, pwc_pkg::OP_INC, 9'h000, 1'b0, 1'b0);
    readback(4'h1, m[1]);
    $display("test step commands done");
    foreach (bads[i]) begin
      cmd(bads[i][5:2], bads[i][1:0], 9'($random(seed)), 1'b1, 1'b1);
      readback(4'h1, m[1]);
    end
    $display("test refused commands done");
    @(posedge clk);
    nvBusy <= 1'b1;
    cmd(pwc_pkg::LOC_STATUS, pwc_pkg::OP_READ, 9'h000, 1'b0, 1'b1);
    readback(4'h4, m[2]);
    nvBusy <= 1'b0;
    readback(pwc_pkg::LOC_STATUS, statusWord);
    $display("test busy reads done");
    stop_test();
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule : testbench
